// [byte_ecc.sv]
// single-error-correcting code for one byte: encoder and corrector
`timescale 1ns/1ps
module byte_ecc (
    // encoder
    input  wire logic [7:0]  dataIn,
    output logic      [11:0] codeOut,
    // corrector
    input  wire logic [11:0] codeIn,
    output logic      [7:0]  dataOut,
    output logic             corrected
);
    // code bit i-1 holds hamming position i, parity at powers of two
    always_comb begin
        int j;
        logic p;
        j = 0;
        p = 1'b0;
        codeOut = '0;
        for (int i = 1; i <= 12; i++) begin
            if ((i & (i - 1)) != 0) begin
                codeOut[i-1] = dataIn[j];
                j = j + 1;
            end
        end
        for (int k = 0; k < 4; k++) begin
            p = 1'b0;
            for (int i = 1; i <= 12; i++) begin
                if (((i >> k) & 1) == 1) begin
                    p = p ^ codeOut[i-1];
                end
            end
            codeOut[(1 << k) - 1] = p;
        end
    end

    always_comb begin
        int j;
        logic [3:0]  syn;
        logic [11:0] fix;
        j = 0;
        syn = '0;
        fix = codeIn;
        dataOut = '0;
        for (int k = 0; k < 4; k++) begin
            for (int i = 1; i <= 12; i++) begin
                if (((i >> k) & 1) == 1) begin
                    syn[k] = syn[k] ^ codeIn[i-1];
                end
            end
        end
        // one flipped bit per byte is repaired
        for (int i = 1; i <= 12; i++) begin
            if (int'(syn) == i) begin
                fix[i-1] = ~codeIn[i-1];
            end
        end
        corrected = (syn != 4'h0);
        for (int i = 1; i <= 12; i++) begin
            if ((i & (i - 1)) != 0) begin
                dataOut[j] = fix[i-1];
                j = j + 1;
            end
        end
    end
endmodule // byte_ecc

// [eeprom_host_model.sv]
// host model driving the serial command port of the eeprom
`timescale 1ns/1ps
module eeprom_host_model (
    // link towards the device
    output logic      shiftClk,
    output logic      chipSelectN,
    output logic      serialIn,
    input  wire logic serialOut,
    input  wire logic serialOutEn
);
    initial begin
        shiftClk    = 1'b1;
        chipSelectN = 1'b1;
        serialIn    = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] addrByte(input logic [5:0] a);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 6; i++) r[7-i] = a[i];
        return r;
    endfunction
    // shift n bits msb first, clock idles high
    task automatic send(input logic [31:0] s, input int n);
        chipSelectN = 1'b0;
        #1000;
        for (int i = 0; i < n; i++) begin
            shiftClk = 1'b0;
            serialIn = s[31-i];
            #32;
            shiftClk = 1'b1;
            #32;
            if (i % 8 == 7) #4000;
        end
    endtask
    // released line shows the inverse of its last value
    task automatic endFrame();
        shiftClk = 1'b1;
        #4000;
        chipSelectN = 1'b1;
        serialIn    = ~serialIn;
        #1000;
    endtask
    task automatic command(input logic [7:0] cmd, input logic [7:0] arg);
        send({cmd, arg, 16'h0000}, 16);
        endFrame();
    endtask
    task automatic write(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] r;
        for (int i = 0; i < 16; i++) r[15-i] = d[i];
        send({eeprom_pkg::CMD_WRITE, addrByte(a), r}, 32);
        endFrame();
    endtask
    task automatic read(input logic [5:0] a, output logic [15:0] d);
        send({eeprom_pkg::CMD_READ, addrByte(a), 16'h0000}, 16);
        for (int i = 0; i < 16; i++) begin
            shiftClk = 1'b0;
            #150;
            d[i]     = serialOut;
            shiftClk = 1'b1;
            #32;
            if (i == 7) #4000;
        end
        endFrame();
    endtask
    // flag sampled after the 17th fall and again later with the clock still low
    task automatic status(input logic [1:0] sel, output logic f, output logic g,
                          output logic e);
        send({eeprom_pkg::CMD_STATUS, sel, 6'h00, 16'h0000}, 16);
        shiftClk = 1'b0;
        #200;
        f = serialOut;
        #2000;
        g = serialOut;
        e = serialOutEn;
        endFrame();
    endtask
endmodule // eeprom_host_model

// [eeprom_pkg.sv]
// constants shared by the serial eeprom status and write-protect logic
package eeprom_pkg;
    // command bytes, first serial bit in the msb
    localparam logic [7:0] CMD_READ   = 8'hA8;
    localparam logic [7:0] CMD_WRITE  = 8'hA1;
    localparam logic [7:0] CMD_UNLOCK = 8'hA3;
    localparam logic [7:0] CMD_LOCK   = 8'hA0;
    localparam logic [7:0] CMD_STATUS = 8'hA9;
    // status flag select, first two bits of the second byte
    localparam logic [1:0] SEL_BUSY = 2'h0;
    localparam logic [1:0] SEL_ECC  = 2'h1;
    localparam logic [1:0] SEL_WEL  = 2'h2;
    // frame layout
    localparam logic [5:0] HEAD_BITS  = 6'h10;
    localparam logic [5:0] FRAME_BITS = 6'h20;
    localparam int         ADDR_W     = 6;
    localparam int         WORDS      = 64;
    localparam int         WORD_W     = 16;
    localparam int         CODE_W     = 12;
    localparam int         ENTRY_W    = 24;
    localparam int         SEL_MSB    = 7;
    localparam int         SEL_LSB    = 6;
    localparam int         ADDR_MSB   = 7;
    localparam int         ADDR_LSB   = 2;
    // latch value 1 means writes are locked
    localparam logic       WEL_RESET  = 1'b1;
    localparam logic       WEL_OPEN   = 1'b0;
    // self-timed write
    localparam int         WRITE_TIME_MS = 15;
    localparam int         REF_PERIOD_NS = 25;
    localparam int         WRITE_CYCLES  = WRITE_TIME_MS * 1000000 / REF_PERIOD_NS;
    localparam int         TIMER_W       = 20;
    localparam logic [3:0] LAST_BIT      = 4'hF;

    typedef enum logic [1:0] {
        OUT_IDLE   = 2'b00,
        OUT_STATUS = 2'b01,
        OUT_READ   = 2'b10
    } outMode_t;
endpackage

// [eeprom_status_and_write_protect.sv]
// serial eeprom core: command sequencer, write-enable latch, busy and ecc flags
`timescale 1ns/1ps
module eeprom_status_and_write_protect #(
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
    // system
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // serial link from the host
    input  wire logic        shiftClk,
    input  wire logic        chipSelectN,
    input  wire logic        serialIn,
    output logic             serialOut,
    output logic             serialOutEn,
    // status pin
    output logic             readyOut,
    // test access that flips one stored code bit
    input  wire logic        faultValid,
    input  wire logic [5:0]  faultAddr,
    input  wire logic [4:0]  faultBit
);
    ////////////////////////////////////////////////////////////////////////////
    // link domain: shift in the frame, cleared while chip select is high
    logic [5:0]  cntQ;
    logic [15:0] headQ;
    logic [15:0] dataQ;
    logic        cmdValidQ;
    logic        wrValidQ;

    always_ff @(posedge shiftClk or posedge chipSelectN) begin
        if (chipSelectN) begin
            cntQ      <= '0;
            headQ     <= '0;
            dataQ     <= '0;
            cmdValidQ <= 1'b0;
            wrValidQ  <= 1'b0;
        end else begin
            if (cntQ < eeprom_pkg::FRAME_BITS) begin
                cntQ <= cntQ + 6'h01;
            end
            if (cntQ < eeprom_pkg::HEAD_BITS) begin
                headQ <= {headQ[14:0], serialIn};
            end else if (cntQ < eeprom_pkg::FRAME_BITS) begin
                dataQ <= {dataQ[14:0], serialIn};
            end
            // levels stay up, with the words frozen, until chip select rises
            if (cntQ == eeprom_pkg::HEAD_BITS - 6'h01) begin
                cmdValidQ <= 1'b1;
            end
            if (cntQ == eeprom_pkg::FRAME_BITS - 6'h01) begin
                wrValidQ <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // crossings into the reference domain
    logic [1:0] csSyncQ;
    logic [2:0] cmdSyncQ;
    logic [2:0] wrSyncQ;
    logic [2:0] sckSyncQ;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            csSyncQ  <= 2'h3;
            cmdSyncQ <= 3'h0;
            wrSyncQ  <= 3'h0;
            sckSyncQ <= 3'h7;
        end else begin
            csSyncQ  <= {csSyncQ[0], chipSelectN};
            cmdSyncQ <= {cmdSyncQ[1:0], cmdValidQ};
            wrSyncQ  <= {wrSyncQ[1:0], wrValidQ};
            sckSyncQ <= {sckSyncQ[1:0], shiftClk};
        end
    end

    logic csHigh;
    logic cmdRise;
    logic wrRise;
    logic sckFall;
    assign csHigh  = csSyncQ[1];
    assign cmdRise = cmdSyncQ[1] & ~cmdSyncQ[2];
    assign wrRise  = wrSyncQ[1] & ~wrSyncQ[2];
    assign sckFall = ~sckSyncQ[1] & sckSyncQ[2];

    ////////////////////////////////////////////////////////////////////////////
    // decode of the frozen frame; serial order puts A0 and D0 first
    function automatic logic [15:0] reverse16(input logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    logic [7:0]  cmd;
    logic [1:0]  sel;
    logic [5:0]  addr;
    logic [15:0] wrWord;
    logic [15:0] headRev;
    assign cmd     = headQ[15:8];
    assign sel     = headQ[eeprom_pkg::SEL_MSB:eeprom_pkg::SEL_LSB];
    assign headRev = reverse16(headQ);
    assign addr    = headRev[15-eeprom_pkg::ADDR_LSB:15-eeprom_pkg::ADDR_MSB];
    assign wrWord  = reverse16(dataQ);

    ////////////////////////////////////////////////////////////////////////////
    // array with per-byte correction
    logic [eeprom_pkg::ENTRY_W-1:0] memQ [eeprom_pkg::WORDS];
    logic [eeprom_pkg::ENTRY_W-1:0] encEntry;
    logic [eeprom_pkg::ENTRY_W-1:0] rdEntry;
    logic [eeprom_pkg::WORD_W-1:0]  decWord;
    logic [1:0]                     corr;
    assign rdEntry = memQ[addr];

    for (genvar b = 0; b < 2; b++) begin : g_byte
        byte_ecc u_ecc (
            .dataIn    (wrWord[8*b +: 8]),
            .codeOut   (encEntry[eeprom_pkg::CODE_W*b +: eeprom_pkg::CODE_W]),
            .codeIn    (rdEntry[eeprom_pkg::CODE_W*b +: eeprom_pkg::CODE_W]),
            .dataOut   (decWord[8*b +: 8]),
            .corrected (corr[b])
        );
    end

    logic welQ;
    logic readyQ;
    logic wrDo;
    assign wrDo = wrRise && cmd == eeprom_pkg::CMD_WRITE && welQ == eeprom_pkg::WEL_OPEN
                  && readyQ;

    always_ff @(posedge ref_clk) begin
        if (wrDo) begin
            memQ[addr] <= encEntry;
        end else if (faultValid) begin
            memQ[faultAddr][faultBit] <= ~memQ[faultAddr][faultBit];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write-enable latch
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            welQ <= eeprom_pkg::WEL_RESET;
        end else if (cmdRise && cmd == eeprom_pkg::CMD_UNLOCK) begin
            welQ <= eeprom_pkg::WEL_OPEN;
        end else if (cmdRise && cmd == eeprom_pkg::CMD_LOCK) begin
            welQ <= eeprom_pkg::WEL_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // self-timed write and ready pin
    logic [eeprom_pkg::TIMER_W-1:0] timerQ;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            readyQ <= 1'b1;
            timerQ <= '0;
        end else if (wrDo) begin
            readyQ <= 1'b0;
            timerQ <= eeprom_pkg::TIMER_W'(WRITE_CYCLES - 1);
        end else if (!readyQ) begin
            if (timerQ == '0) begin
                readyQ <= 1'b1;
            end else begin
                timerQ <= timerQ - 1'b1;
            end
        end
    end
    assign readyOut = readyQ;

    ////////////////////////////////////////////////////////////////////////////
    // correction flag, updated by each read
    logic eccFlagQ;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            eccFlagQ <= 1'b0;
        end else if (cmdRise && cmd == eeprom_pkg::CMD_READ) begin
            eccFlagQ <= |corr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial output
    eeprom_pkg::outMode_t modeQ;
    logic [1:0]          selQ;
    logic [15:0]         readWordQ;
    logic [3:0]          bitIdxQ;
    logic                outEnQ;
    logic                outQ;
    logic                flag;

    always_comb begin
        unique case (selQ)
            eeprom_pkg::SEL_WEL: flag = welQ;
            eeprom_pkg::SEL_ECC: flag = eccFlagQ;
            default:             flag = readyQ;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset || csHigh) begin
            modeQ <= eeprom_pkg::OUT_IDLE;
            selQ  <= eeprom_pkg::SEL_BUSY;
        end else if (cmdRise && cmd == eeprom_pkg::CMD_READ) begin
            modeQ     <= eeprom_pkg::OUT_READ;
            readWordQ <= decWord;
        end else if (cmdRise && cmd == eeprom_pkg::CMD_STATUS) begin
            modeQ <= eeprom_pkg::OUT_STATUS;
            selQ  <= sel;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || csHigh) begin
            outEnQ  <= 1'b0;
            outQ    <= 1'b0;
            bitIdxQ <= '0;
        end else if (modeQ == eeprom_pkg::OUT_STATUS) begin
            if (sckFall) begin
                outEnQ <= 1'b1;
            end
            outQ <= flag;
        end else if (modeQ == eeprom_pkg::OUT_READ && sckFall) begin
            outEnQ <= 1'b1;
            outQ   <= readWordQ[bitIdxQ];
            if (bitIdxQ != eeprom_pkg::LAST_BIT) begin
                bitIdxQ <= bitIdxQ + 4'h1;
            end
        end
    end
    assign serialOut   = outQ;
    assign serialOutEn = outEnQ;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_busy_pin_match: assert property (
        outEnQ && modeQ == eeprom_pkg::OUT_STATUS && selQ == eeprom_pkg::SEL_BUSY
        && $stable(readyQ) |-> serialOut == readyOut)
        else $error("busy flag differs from ready pin");
    a_status_start: assert property (
        modeQ == eeprom_pkg::OUT_STATUS && sckFall && !csHigh |=> outEnQ)
        else $error("status output not started on falling clock");
    a_locked_write: assert property (
        wrRise && welQ != eeprom_pkg::WEL_OPEN && readyQ |=> readyQ)
        else $error("write started while latch locked");
    a_latch_cmd_only: assert property (
        $changed(welQ) |-> $past(cmdRise)
        && ($past(cmd) == eeprom_pkg::CMD_UNLOCK || $past(cmd) == eeprom_pkg::CMD_LOCK))
        else $error("latch changed without its command");
    a_unlock_holds: assert property (
        welQ == eeprom_pkg::WEL_OPEN && !(cmdRise && cmd == eeprom_pkg::CMD_LOCK)
        |=> welQ == eeprom_pkg::WEL_OPEN)
        else $error("latch left enabled state without lock");
    a_read_any_latch: assert property (
        cmdRise && cmd == eeprom_pkg::CMD_READ && !csHigh |=> modeQ == eeprom_pkg::OUT_READ)
        else $error("read not accepted");
    a_ecc_flag_set: assert property (
        cmdRise && cmd == eeprom_pkg::CMD_READ && corr != 2'h0 |=> eccFlagQ ##1 eccFlagQ)
        else $error("correction flag not set");
    a_ecc_flag_clear: assert property (
        cmdRise && cmd == eeprom_pkg::CMD_READ && corr == 2'h0 |=> !eccFlagQ)
        else $error("correction flag not cleared");
    a_status_hold: assert property (
        outEnQ && !csHigh |=> outEnQ)
        else $error("status output dropped before chip select high");
    a_cs_idle: assert property (
        csHigh |=> !outEnQ && modeQ == eeprom_pkg::OUT_IDLE)
        else $error("output active while chip select high");
endmodule // eeprom_status_and_write_protect

// [testbench.sv]
// self-checking bench for the eeprom status and write-protect core
`timescale 1ns/1ps
module testbench;
    logic        ref_clk;
    logic        reset;
    logic        shiftClk;
    logic        chipSelectN;
    logic        serialIn;
    logic        serialOut;
    logic        serialOutEn;
    logic        readyOut;
    logic        faultValid;
    logic [5:0]  faultAddr;
    logic [4:0]  faultBit;
    int          nMismatch;
    int          testsRun;
    logic [15:0] rd;
    logic        f;
    logic        g;
    logic        e;

    eeprom_status_and_write_protect #(.WRITE_CYCLES(2000)) eeprom_status_and_write_protect_i (
        .ref_clk(ref_clk), .reset(reset), .shiftClk(shiftClk), .chipSelectN(chipSelectN),
        .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .readyOut(readyOut), .faultValid(faultValid), .faultAddr(faultAddr),
        .faultBit(faultBit));
    eeprom_host_model eeprom_host_model_i (
        .shiftClk(shiftClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn));

    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic printVerdict();
        if (nMismatch == 0 && testsRun > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic waitReady();
        for (int i = 0; i < 3000 && readyOut !== 1'b1; i++) @(negedge ref_clk);
        check(readyOut, 1'b1);
    endtask
    // status frame, flag must hold and line release afterwards
    task automatic expectFlag(input logic [1:0] sel, input logic exp);
        eeprom_host_model_i.status(sel, f, g, e);
        check(f, exp);
        check(g, exp);
        check(e, 1'b1);
        check(serialOutEn, 1'b0);
    endtask
    task automatic inject(input logic [5:0] a, input logic [4:0] b);
        @(negedge ref_clk);
        faultValid = 1'b1;
        faultAddr  = a;
        faultBit   = b;
        @(negedge ref_clk);
        faultValid = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check(readyOut, 1'b1);
        check(serialOutEn, 1'b0);
        expectFlag(eeprom_pkg::SEL_WEL, eeprom_pkg::WEL_RESET);
        expectFlag(eeprom_pkg::SEL_BUSY, 1'b1);
        expectFlag(2'h3, 1'b1);
    endtask
    task automatic t_unlock_write();
        eeprom_host_model_i.command(eeprom_pkg::CMD_UNLOCK, 8'h5A);
        expectFlag(eeprom_pkg::SEL_WEL, eeprom_pkg::WEL_OPEN);
        eeprom_host_model_i.write(6'h05, 16'h1234);
        check(readyOut, 1'b0);
        expectFlag(eeprom_pkg::SEL_BUSY, 1'b0);
        check(readyOut, 1'b0);
        waitReady();
        eeprom_host_model_i.write(6'h2A, 16'hABCD);
        waitReady();
        expectFlag(eeprom_pkg::SEL_WEL, eeprom_pkg::WEL_OPEN);
        eeprom_host_model_i.read(6'h05, rd);
        check(rd, 16'h1234);
        eeprom_host_model_i.read(6'h2A, rd);
        check(rd, 16'hABCD);
        // an unknown command must leave the open latch alone
        eeprom_host_model_i.command(8'hFF, 8'h00);
        expectFlag(eeprom_pkg::SEL_WEL, eeprom_pkg::WEL_OPEN);
    endtask
    task automatic t_lock();
        eeprom_host_model_i.command(eeprom_pkg::CMD_LOCK, 8'hFF);
        expectFlag(eeprom_pkg::SEL_WEL, eeprom_pkg::WEL_RESET);
        eeprom_host_model_i.write(6'h05, 16'h0F0F);
        check(readyOut, 1'b1);
        eeprom_host_model_i.command(8'hFF, 8'h00);
        expectFlag(eeprom_pkg::SEL_WEL, eeprom_pkg::WEL_RESET);
        eeprom_host_model_i.read(6'h05, rd);
        check(rd, 16'h1234);
    endtask
    task automatic t_ecc();
        eeprom_host_model_i.read(6'h2A, rd);
        check(rd, 16'hABCD);
        expectFlag(eeprom_pkg::SEL_ECC, 1'b0);
        inject(6'h05, 5'h02);
        inject(6'h05, 5'h11);
        eeprom_host_model_i.read(6'h05, rd);
        check(rd, 16'h1234);
        expectFlag(eeprom_pkg::SEL_ECC, 1'b1);
        inject(6'h2A, 5'h0B);
        eeprom_host_model_i.read(6'h2A, rd);
        check(rd, 16'hABCD);
        expectFlag(eeprom_pkg::SEL_ECC, 1'b1);
        eeprom_host_model_i.command(eeprom_pkg::CMD_UNLOCK, 8'h00);
        eeprom_host_model_i.write(6'h11, 16'h8001);
        waitReady();
        eeprom_host_model_i.read(6'h11, rd);
        check(rd, 16'h8001);
        expectFlag(eeprom_pkg::SEL_ECC, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        nMismatch  = 0;
        testsRun   = 0;
        reset      = 1'b1;
        faultValid = 1'b0;
        faultAddr  = 6'h00;
        faultBit   = 5'h00;
        repeat (10) @(negedge ref_clk);
        reset = 1'b0;
        repeat (5) @(negedge ref_clk);
        t_reset();
        t_unlock_write();
        t_lock();
        t_ecc();
        printVerdict();
    end
    // watchdog for a hung handshake, about three times the expected run
    initial begin
        #2000000;
        nMismatch++;
        printVerdict();
    end
endmodule // testbench
